// ===== logic/qpv_pkg.sv
// Package: register map, field layout and constants of the position and velocity capture block
package qpv_pkg;
   localparam int          ADDR_W          = 4;
   localparam int          DATA_W          = 32;
   localparam int          SYNC_STAGES     = 2;
   localparam logic [3:0]  ADDR_CTRL       = 4'h0;
   localparam logic [3:0]  ADDR_POSITION   = 4'h1;
   localparam logic [3:0]  ADDR_LIMIT      = 4'h2;
   localparam logic [3:0]  ADDR_PERIOD     = 4'h3;
   localparam logic [3:0]  ADDR_VELOCITY   = 4'h4;
   localparam logic [3:0]  ADDR_STATUS     = 4'h5;
   localparam logic [3:0]  ADDR_INT_STAT   = 4'h6;
   localparam logic [3:0]  ADDR_INT_MASK   = 4'h7;
   // Control register fields
   localparam int          CTRL_ENABLE     = 0;
   localparam int          CTRL_VEL_EN     = 1;
   localparam int          CTRL_BOTH       = 2;
   localparam int          CTRL_RST_IDX    = 3;
   localparam int          CTRL_CLKDIR     = 4;
   localparam int          CTRL_SWAP       = 5;
   localparam int          CTRL_DIV_LSB    = 8;
   localparam int          CTRL_DIV_W      = 3;
   localparam int          CTRL_W          = 11;
   // Interrupt bits
   localparam int          INT_ERROR       = 0;
   localparam int          INT_DIR         = 1;
   localparam int          INT_TIMER       = 2;
   localparam int          INT_INDEX       = 3;
   localparam int          INT_W           = 4;
   // Status register fields
   localparam int          STAT_ERROR      = 0;
   localparam int          STAT_DIR        = 1;
   localparam int          STAT_IDX_SEEN   = 2;
   localparam logic [CTRL_W-1:0] CTRL_RESET   = 11'h000;
   localparam logic [31:0]       LIMIT_RESET  = 32'hFFFFFFFF;
   localparam logic [31:0]       PERIOD_RESET = 32'h00000001;
   localparam int          PREDIV_MAX_LOG2 = 7;
endpackage : qpv_pkg

// ===== logic/qpv_edge_if.sv
// Interface: decoded encoder events passed from the decoder to the counters
`timescale 1ns/100ps
interface qpv_edge_if;
   logic step;
   logic forward;
   logic index;
   logic error;
   modport decoder (output step, output forward, output index, output error);
   modport counter (input step, input forward, input index, input error);
endinterface : qpv_edge_if

// ===== logic/qpv_decoder.sv
// Module: encoder pin synchroniser and edge decoder
`timescale 1ns/100ps
module qpv_decoder
(
   input  wire logic  clk,            // System clock
   input  wire logic  sys_rst,        // Async reset, active high
   input  wire logic  phase_a_input,  // Encoder channel A pin
   input  wire logic  phase_b_input,  // Encoder channel B pin
   input  wire logic  index_input,    // Encoder index pin
   input  wire logic  swap_channels,  // Swap A and B before decoding
   input  wire logic  clock_direction_input, // Clock on A, direction on B
   input  wire logic  count_both_channels,   // Count B edges too
   qpv_edge_if.decoder ev              // Decoded events
);
   logic [2:0] meta_ff;
   logic [2:0] sync_ff;
   logic [2:0] prev_ff;
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         meta_ff <= 3'h0;
         sync_ff <= 3'h0;
         prev_ff <= 3'h0;
      end
      else
      begin
         meta_ff <= {index_input, phase_b_input, phase_a_input};
         sync_ff <= meta_ff;
         prev_ff <= sync_ff;
      end
   end
   wire        a_now    = swap_channels ? sync_ff[1] : sync_ff[0];
   wire        b_now    = swap_channels ? sync_ff[0] : sync_ff[1];
   wire        a_old    = swap_channels ? prev_ff[1] : prev_ff[0];
   wire        b_old    = swap_channels ? prev_ff[0] : prev_ff[1];
   wire        a_chg    = a_now ^ a_old;
   wire        b_chg    = b_now ^ b_old;
   // Quadrature: forward when A leads B
   wire        quad_fwd = a_chg ? (a_now ^ b_now) : ~(a_now ^ b_now);
   wire        quad_stp = (a_chg ^ b_chg) & (a_chg | count_both_channels);
   wire        cd_stp   = a_now & ~a_old;
   assign ev.step    = clock_direction_input ? cd_stp : quad_stp;
   assign ev.forward = clock_direction_input ? ~b_now : quad_fwd;
   assign ev.index   = sync_ff[2] & ~prev_ff[2];
   assign ev.error   = ~clock_direction_input & a_chg & b_chg;
endmodule : qpv_decoder

// ===== logic/qpv_capture.sv
// Module: quadrature position integrator and velocity capture with register port
// Notes on behaviour
// - Divided pulses reach velocity accumulator; divide factor 1 to 128, powers of two.
// - Accumulate per period; at end store total as velocity and clear.
// - Separate velocity enable; configure before setting it.
// - No velocity accumulation while the whole unit is disabled.
// - Velocity read returns last completed period count, unsigned.
// - Position write loads integrator at once; counting continues from it.
// - Position read returns live value; unaligned until first index in index mode.
// - Count channel A edges only or both, for position and velocity.
// - Index resets position; reverse direction loads the limit instead.
// - Quadrature or clock plus direction input, optional channel swap.
// - Error flagged in quadrature mode when both channels change in one sample.
//
// Our own choices: the placing of the registers and the plain strobed port.
`timescale 1ns/100ps
module qpv_capture
(
   input  wire logic        clk,            // System clock 10 MHz
   input  wire logic        sys_rst,        // Async reset, active high
   input  wire logic        phase_a_input,  // Encoder channel A pin
   input  wire logic        phase_b_input,  // Encoder channel B pin
   input  wire logic        index_input,    // Encoder index pin
   input  wire logic [3:0]  reg_addr,       // Register word address
   input  wire logic [31:0] reg_wdata,      // Write data
   input  wire logic        reg_wr,         // Write strobe
   input  wire logic        reg_rd,         // Read strobe
   output logic      [31:0] reg_rdata,      // Read data, cycle after strobe
   output logic             irq             // Level interrupt
);
   logic [qpv_pkg::CTRL_W-1:0] ctrl_ff;
   logic [31:0]                position_ff;
   logic [31:0]                limit_ff;
   logic [31:0]                period_ff;
   logic [31:0]                accum_ff;
   logic [31:0]                velocity_ff;
   logic [31:0]                tick_ff;
   logic [6:0]                 prediv_ff;
   logic                       error_ff;
   logic                       dir_ff;
   logic                       idx_seen_ff;
   logic [qpv_pkg::INT_W-1:0]  int_stat_ff;
   logic [qpv_pkg::INT_W-1:0]  int_mask_ff;
   logic [31:0]                rdata_ff;
   logic                       irq_ff;

   qpv_edge_if ev ();

   qpv_decoder u_dec
   (
      .clk                   (clk),
      .sys_rst               (sys_rst),
      .phase_a_input         (phase_a_input),
      .phase_b_input         (phase_b_input),
      .index_input           (index_input),
      .swap_channels         (ctrl_ff[qpv_pkg::CTRL_SWAP]),
      .clock_direction_input (ctrl_ff[qpv_pkg::CTRL_CLKDIR]),
      .count_both_channels   (ctrl_ff[qpv_pkg::CTRL_BOTH]),
      .ev                    (ev.decoder)
   );

   function automatic logic [31:0] pick(input logic [3:0] a, input logic [3:0] b);
      pick = (a == b) ? 32'hFFFFFFFF : 32'h00000000;
   endfunction : pick

   wire        enable        = ctrl_ff[qpv_pkg::CTRL_ENABLE];
   wire        vel_on        = enable & ctrl_ff[qpv_pkg::CTRL_VEL_EN];
   wire        reset_on_index = ctrl_ff[qpv_pkg::CTRL_RST_IDX];
   wire [2:0]  velocity_predivider = ctrl_ff[qpv_pkg::CTRL_DIV_LSB +: qpv_pkg::CTRL_DIV_W];
   wire        step          = enable & ev.step;
   wire        err_evt       = enable & ev.error;
   wire        idx_evt       = enable & ev.index;
   wire        dir_evt       = step & (ev.forward != dir_ff);

   wire        wr_ctrl       = reg_wr & (reg_addr == qpv_pkg::ADDR_CTRL);
   wire        wr_pos        = reg_wr & (reg_addr == qpv_pkg::ADDR_POSITION);
   wire        wr_limit      = reg_wr & (reg_addr == qpv_pkg::ADDR_LIMIT);
   wire        wr_period     = reg_wr & (reg_addr == qpv_pkg::ADDR_PERIOD);
   wire        wr_istat      = reg_wr & (reg_addr == qpv_pkg::ADDR_INT_STAT);
   wire        wr_imask      = reg_wr & (reg_addr == qpv_pkg::ADDR_INT_MASK);

   // Position next value; index wins over a step in the same cycle
   wire [31:0] pos_fwd       = (position_ff >= limit_ff) ? 32'h00000000 : position_ff + 32'h00000001;
   wire [31:0] pos_rev       = (position_ff == 32'h00000000) ? limit_ff : position_ff - 32'h00000001;
   wire [31:0] pos_idx       = dir_ff ? 32'h00000000 : limit_ff;
   wire [31:0] nxt_position  = wr_pos ? reg_wdata :
                               (idx_evt & reset_on_index) ? pos_idx :
                               step ? (ev.forward ? pos_fwd : pos_rev) : position_ff;

   // Predivider: terminal count 2^n - 1, so factor 1 passes every step
   wire [6:0]  prediv_tc     = 7'((8'h01 << velocity_predivider) - 8'h01);
   wire        prediv_hit    = step & (prediv_ff == prediv_tc);
   wire [6:0]  nxt_prediv    = ~vel_on ? 7'h00 : step ? (prediv_hit ? 7'h00 : prediv_ff + 7'h01) : prediv_ff;
   wire        vel_pulse     = vel_on & prediv_hit;

   // Period of zero is treated as one tick; software must not program it
   wire        period_end    = vel_on & (tick_ff + 32'h00000001 >= period_ff);
   wire [31:0] accum_inc     = accum_ff + {31'h00000000, vel_pulse};
   wire [31:0] nxt_tick      = (~vel_on | period_end) ? 32'h00000000 : tick_ff + 32'h00000001;
   wire [31:0] nxt_accum     = ~vel_on ? 32'h00000000 : period_end ? 32'h00000000 : accum_inc;
   wire [31:0] nxt_velocity  = period_end ? accum_inc : velocity_ff;

   wire [qpv_pkg::INT_W-1:0] int_set;
   assign int_set[qpv_pkg::INT_ERROR] = err_evt;
   assign int_set[qpv_pkg::INT_DIR]   = dir_evt;
   assign int_set[qpv_pkg::INT_TIMER] = period_end;
   assign int_set[qpv_pkg::INT_INDEX] = idx_evt;
   // Set beats write-one-to-clear so no event is lost
   wire [qpv_pkg::INT_W-1:0] nxt_int_stat = int_set |
                               (int_stat_ff & ~(wr_istat ? reg_wdata[qpv_pkg::INT_W-1:0] : 4'h0));
   wire [qpv_pkg::INT_W-1:0] nxt_int_mask = wr_imask ? reg_wdata[qpv_pkg::INT_W-1:0] : int_mask_ff;
   wire        nxt_irq       = |(nxt_int_stat & nxt_int_mask);

   wire [31:0] status_word   = {29'h00000000, idx_seen_ff, dir_ff, error_ff};
   wire [31:0] nxt_rdata     = ~reg_rd ? 32'h00000000 :
                               (pick(reg_addr, qpv_pkg::ADDR_CTRL)     & {21'h000000, ctrl_ff})     |
                               (pick(reg_addr, qpv_pkg::ADDR_POSITION) & position_ff)               |
                               (pick(reg_addr, qpv_pkg::ADDR_LIMIT)    & limit_ff)                  |
                               (pick(reg_addr, qpv_pkg::ADDR_PERIOD)   & period_ff)                 |
                               (pick(reg_addr, qpv_pkg::ADDR_VELOCITY) & velocity_ff)               |
                               (pick(reg_addr, qpv_pkg::ADDR_STATUS)   & status_word)               |
                               (pick(reg_addr, qpv_pkg::ADDR_INT_STAT) & {28'h0000000, int_stat_ff}) |
                               (pick(reg_addr, qpv_pkg::ADDR_INT_MASK) & {28'h0000000, int_mask_ff});

   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         ctrl_ff   <= qpv_pkg::CTRL_RESET;
         limit_ff  <= qpv_pkg::LIMIT_RESET;
         period_ff <= qpv_pkg::PERIOD_RESET;
      end
      else
      begin
         if (wr_ctrl)
            ctrl_ff <= reg_wdata[qpv_pkg::CTRL_W-1:0];
         if (wr_limit)
            limit_ff <= reg_wdata;
         if (wr_period)
            period_ff <= reg_wdata;
      end
   end

   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         position_ff <= 32'h00000000;
         prediv_ff   <= 7'h00;
         tick_ff     <= 32'h00000000;
         accum_ff    <= 32'h00000000;
         velocity_ff <= 32'h00000000;
      end
      else
      begin
         position_ff <= nxt_position;
         prediv_ff   <= nxt_prediv;
         tick_ff     <= nxt_tick;
         accum_ff    <= nxt_accum;
         velocity_ff <= nxt_velocity;
      end
   end

   // Error indicator is sticky until a control write while the unit is off
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         error_ff    <= 1'b0;
         dir_ff      <= 1'b1;
         idx_seen_ff <= 1'b0;
      end
      else
      begin
         error_ff    <= err_evt | (error_ff & ~(wr_ctrl & ~enable));
         if (step)
            dir_ff <= ev.forward;
         idx_seen_ff <= idx_evt | (idx_seen_ff & ~wr_pos);
      end
   end

   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         int_stat_ff <= 4'h0;
         int_mask_ff <= 4'h0;
         rdata_ff    <= 32'h00000000;
         irq_ff      <= 1'b0;
      end
      else
      begin
         int_stat_ff <= nxt_int_stat;
         int_mask_ff <= nxt_int_mask;
         rdata_ff    <= nxt_rdata;
         irq_ff      <= nxt_irq;
      end
   end

   assign reg_rdata = rdata_ff;
   assign irq       = irq_ff;
endmodule : qpv_capture

// ===== tb/qpv_capture_properties.sv
// Checker: register port, interrupt and position load properties
`timescale 1ns/100ps
module qpv_capture_properties
(
   input wire logic        clk,           // System clock
   input wire logic        sys_rst,       // Async reset
   input wire logic        phase_a_input, // Channel A pin
   input wire logic        phase_b_input, // Channel B pin
   input wire logic        index_input,   // Index pin
   input wire logic [3:0]  reg_addr,      // Word address
   input wire logic [31:0] reg_wdata,     // Write data
   input wire logic        reg_wr,        // Write strobe
   input wire logic        reg_rd,        // Read strobe
   input wire logic [31:0] reg_rdata,     // Read data
   input wire logic        irq            // Interrupt
);
   logic [2:0] pins_ff;
   logic [3:0] quiet_ff;
   logic [3:0] nxt_quiet;
   // Cycles since any pin moved, so steps still in the synchroniser are excluded
   assign nxt_quiet = ({phase_a_input, phase_b_input, index_input} != pins_ff) ? 4'h0 :
                      (quiet_ff == 4'hF) ? quiet_ff : quiet_ff + 4'h1;
   always_ff @(posedge clk or posedge sys_rst)
      if (sys_rst)
         {pins_ff, quiet_ff} <= 7'h00;
      else
         {pins_ff, quiet_ff} <= {phase_a_input, phase_b_input, index_input, nxt_quiet};
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);
   property p_readback(logic [3:0] a, logic [31:0] m);
      reg_wr && reg_addr == a ##1 !reg_wr ##1 reg_rd && reg_addr == a |=> (reg_rdata & m) == ($past(reg_wdata, 3) & m);
   endproperty
   a_rdata_idle: assert property (!reg_rd |=> reg_rdata == 32'h0)
      else $error("read data not zero outside a read");
   a_unmapped_zero: assert property (reg_rd && reg_addr > qpv_pkg::ADDR_INT_MASK |=> reg_rdata == 32'h0)
      else $error("unmapped read returned data");
   a_status_upper: assert property (reg_rd && reg_addr == qpv_pkg::ADDR_STATUS |=> reg_rdata[31:3] == 29'h0)
      else $error("status upper bits not zero");
   a_ctrl_readback: assert property (p_readback(qpv_pkg::ADDR_CTRL, 32'h0000073F))
      else $error("control readback differs from write");
   a_limit_readback: assert property (p_readback(qpv_pkg::ADDR_LIMIT, 32'hFFFFFFFF))
      else $error("limit readback differs from write");
   a_period_readback: assert property (p_readback(qpv_pkg::ADDR_PERIOD, 32'hFFFFFFFF))
      else $error("period readback differs from write");
   a_position_load: assert property (quiet_ff > 4'h5 && reg_wr && reg_addr == qpv_pkg::ADDR_POSITION
      ##1 !reg_wr ##1 reg_rd && reg_addr == qpv_pkg::ADDR_POSITION |=> reg_rdata == $past(reg_wdata, 3))
      else $error("position not loaded by write");
   a_mask_silences: assert property (reg_wr && reg_addr == qpv_pkg::ADDR_INT_MASK && reg_wdata[3:0] == 4'h0
      ##1 !(reg_wr && reg_addr == qpv_pkg::ADDR_INT_MASK) |=> !irq)
      else $error("interrupt high with all sources masked");
   c_irq_raised: cover property ($rose(irq));
   c_vel_read: cover property (reg_rd && reg_addr == qpv_pkg::ADDR_VELOCITY ##1 reg_rdata != 32'h0);
   c_pos_reload: cover property (reg_wr && reg_addr == qpv_pkg::ADDR_POSITION && quiet_ff > 4'h5);
endmodule : qpv_capture_properties
bind qpv_capture qpv_capture_properties qpv_capture_properties_inst (.clk(clk), .sys_rst(sys_rst),
   .phase_a_input(phase_a_input), .phase_b_input(phase_b_input), .index_input(index_input), .reg_addr(reg_addr),
   .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq));

// ===== tb/qpv_encoder_model.sv
// Partner: incremental encoder driving channel A, channel B and index
`timescale 1ns/100ps
module qpv_encoder_model
(
   input  wire logic clk,           // Paces the pin changes
   output logic      phase_a_input, // Channel A or clock
   output logic      phase_b_input, // Channel B or direction
   output logic      index_input    // Index pulse
);
   logic [1:0] step_cnt;
   initial
   begin
      phase_a_input = 1'b0;
      phase_b_input = 1'b0;
      index_input   = 1'b0;
   end
   // Three more cycles after each change so it clears the synchroniser
   task automatic hold();
      repeat (3) @(posedge clk);
   endtask : hold
   // Forward means A leads B
   task automatic quad(input bit fwd, input int n);
      repeat (n)
      begin
         step_cnt = {phase_b_input, phase_a_input ^ phase_b_input} + (fwd ? 2'h1 : 2'h3);
         @(posedge clk);
         phase_a_input <= step_cnt[0] ^ step_cnt[1];
         phase_b_input <= step_cnt[1];
         hold();
      end
   endtask : quad
   task automatic pulse(input bit fwd, input int n);
      @(posedge clk);
      phase_a_input <= 1'b0;
      phase_b_input <= ~fwd;
      hold();
      repeat (n)
      begin
         @(posedge clk);
         phase_a_input <= 1'b1;
         hold();
         @(posedge clk);
         phase_a_input <= 1'b0;
         hold();
      end
   endtask : pulse
   task automatic index_pulse();
      @(posedge clk);
      index_input <= 1'b1;
      hold();
      @(posedge clk);
      index_input <= 1'b0;
      hold();
   endtask : index_pulse
   // Deliberate fault: both channels flip together
   task automatic jump();
      @(posedge clk);
      phase_a_input <= ~phase_a_input;
      phase_b_input <= ~phase_b_input;
      hold();
   endtask : jump
endmodule : qpv_encoder_model

// ===== tb/qpv_capture_test.sv
// Testbench: position and velocity capture against the encoder model
`timescale 1ns/100ps
module qpv_capture_test;
   typedef struct {logic [31:0] ctrl; bit cd; int n; logic [31:0] vel;} qpv_row_type;
   logic        clk = 1'b0, sys_rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
   logic        phase_a_input, phase_b_input, index_input, irq;
   logic [3:0]  reg_addr = 4'h0;
   logic [31:0] reg_wdata = 32'h0, reg_rdata;
   int          err_count = 0, total_checks = 0;
   qpv_row_type rows [11] = '{'{32'h007, 0, 256, 256}, '{32'h107, 0, 256, 128}, '{32'h207, 0, 256, 64},
      '{32'h307, 0, 256, 32}, '{32'h407, 0, 256, 16}, '{32'h507, 0, 256, 8}, '{32'h607, 0, 256, 4},
      '{32'h707, 0, 256, 2}, '{32'h003, 0, 256, 128}, '{32'h013, 1, 64, 64}, '{32'h213, 1, 64, 16}};
   always #50 clk = ~clk;
   qpv_capture qpv_capture_inst (.clk(clk), .sys_rst(sys_rst), .phase_a_input(phase_a_input),
      .phase_b_input(phase_b_input), .index_input(index_input), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq));
   qpv_encoder_model qpv_encoder_model_inst (.clk(clk), .phase_a_input(phase_a_input),
      .phase_b_input(phase_b_input), .index_input(index_input));
   task automatic end_sim();
      if (err_count == 0 && total_checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : end_sim
   task automatic chk(input string name, input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp)
      begin
         err_count++;
         $display("BAD %s expected %h seen %h", name, exp, got);
      end
   endtask : chk
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge clk);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge clk);
      reg_wr    <= 1'b0;
   endtask : wr
   task automatic rchk(input logic [3:0] a, input logic [31:0] exp, input logic [31:0] m);
      @(posedge clk);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge clk);
      reg_rd   <= 1'b0;
      #1;
      chk($sformatf("reg %h", a), reg_rdata & m, exp);
   endtask : rchk
   task automatic irqchk(input logic exp);
      repeat (3) @(posedge clk);
      #1;
      chk("irq", {31'h0, irq}, {31'h0, exp});
   endtask : irqchk
   task automatic move(input bit cd, input bit fwd, input int n);
      if (cd)
         qpv_encoder_model_inst.pulse(fwd, n);
      else
         qpv_encoder_model_inst.quad(fwd, n);
   endtask : move
   initial
   begin
      repeat (80000) @(posedge clk);
      err_count++;
      end_sim();
   end
   initial
   begin
      repeat (12) @(posedge clk);
      sys_rst <= 1'b0;
      rchk(qpv_pkg::ADDR_LIMIT, 32'hFFFFFFFF, '1);
      rchk(qpv_pkg::ADDR_PERIOD, 32'h1, '1);
      rchk(qpv_pkg::ADDR_POSITION, 32'h0, '1);
      rchk(qpv_pkg::ADDR_VELOCITY, 32'h0, '1);
      rchk(4'hF, 32'h0, '1);
      wr(qpv_pkg::ADDR_PERIOD, 32'h000007D0);
      rchk(qpv_pkg::ADDR_PERIOD, 32'h000007D0, '1);
      foreach (rows[i])
      begin
         wr(qpv_pkg::ADDR_CTRL, 32'h0);
         wr(qpv_pkg::ADDR_CTRL, rows[i].ctrl);
         wr(qpv_pkg::ADDR_POSITION, 32'h0);
         rchk(qpv_pkg::ADDR_POSITION, 32'h0, '1);
         move(rows[i].cd, 1'b1, rows[i].n);
         repeat (1800) @(posedge clk);
         rchk(qpv_pkg::ADDR_VELOCITY, rows[i].vel, '1);
         // Position is undivided, so it holds the velocity times the predivide factor
         rchk(qpv_pkg::ADDR_POSITION, rows[i].vel << rows[i].ctrl[qpv_pkg::CTRL_DIV_LSB +: qpv_pkg::CTRL_DIV_W], '1);
         move(rows[i].cd, 1'b0, rows[i].n);
         rchk(qpv_pkg::ADDR_POSITION, 32'h0, '1);
      end
      wr(qpv_pkg::ADDR_CTRL, 32'h011);
      wr(qpv_pkg::ADDR_POSITION, 32'h7);
      wr(qpv_pkg::ADDR_LIMIT, 32'h9);
      rchk(qpv_pkg::ADDR_LIMIT, 32'h9, '1);
      move(1'b1, 1'b1, 3);
      rchk(qpv_pkg::ADDR_POSITION, 32'h0, '1);
      move(1'b1, 1'b0, 1);
      rchk(qpv_pkg::ADDR_POSITION, 32'h9, '1);
      wr(qpv_pkg::ADDR_CTRL, 32'h019);
      wr(qpv_pkg::ADDR_POSITION, 32'h5);
      move(1'b1, 1'b1, 1);
      qpv_encoder_model_inst.index_pulse();
      rchk(qpv_pkg::ADDR_POSITION, 32'h0, '1);
      move(1'b1, 1'b0, 2);
      qpv_encoder_model_inst.index_pulse();
      rchk(qpv_pkg::ADDR_POSITION, 32'h9, '1);
      rchk(qpv_pkg::ADDR_STATUS, 32'h4, 32'h6);
      // Unit off with velocity on: neither counter may move
      wr(qpv_pkg::ADDR_CTRL, 32'h002);
      move(1'b0, 1'b1, 64);
      rchk(qpv_pkg::ADDR_POSITION, 32'h9, '1);
      wr(qpv_pkg::ADDR_CTRL, 32'h003);
      repeat (2500) @(posedge clk);
      rchk(qpv_pkg::ADDR_VELOCITY, 32'h0, '1);
      wr(qpv_pkg::ADDR_CTRL, 32'h001);
      move(1'b0, 1'b1, 64);
      repeat (2500) @(posedge clk);
      rchk(qpv_pkg::ADDR_VELOCITY, 32'h0, '1);
      wr(qpv_pkg::ADDR_CTRL, 32'h0);
      wr(qpv_pkg::ADDR_CTRL, 32'h005);
      rchk(qpv_pkg::ADDR_CTRL, 32'h005, 32'h73F);
      // Direction, period end and index have all fired by now; no error yet
      rchk(qpv_pkg::ADDR_INT_STAT, 32'hE, 32'hF);
      wr(qpv_pkg::ADDR_INT_STAT, 32'hF);
      wr(qpv_pkg::ADDR_INT_MASK, 32'h1);
      irqchk(1'b0);
      qpv_encoder_model_inst.jump();
      irqchk(1'b1);
      rchk(qpv_pkg::ADDR_STATUS, 32'h1, 32'h1);
      rchk(qpv_pkg::ADDR_INT_STAT, 32'h1, 32'hF);
      wr(qpv_pkg::ADDR_INT_MASK, 32'h0);
      irqchk(1'b0);
      wr(qpv_pkg::ADDR_INT_MASK, 32'h1);
      irqchk(1'b1);
      wr(qpv_pkg::ADDR_INT_STAT, 32'h1);
      irqchk(1'b0);
      end_sim();
   end
endmodule : qpv_capture_test
